// *** common/bil_pkg.sv ***
// Shared constants, states and carrier types of the boot image loader
package bil_pkg;

  // ----------------------------------------------------------------------
  // Security register and image constants
  // ----------------------------------------------------------------------
  localparam int SEC_BOOT_BIT = 5;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_PRESET = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_BYPASS = 32'h0D15AB1E;
  localparam logic [31:0] EXEC_ADDR = 32'h0000_0000;
  localparam logic [31:0] OTP_BASE = 32'h0000_0000;
  localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
  localparam int BYTE_LANES = 4;
  localparam int RAM_WORDS = 32768;

  // ----------------------------------------------------------------------
  // Timing: internal reset phase, least time rounded up to cycles
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int INT_RST_NS = 15000;
  localparam int INT_RST_CYC = (INT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    BIL_HELD = 4'h0,
    BIL_INT_RST = 4'h1,
    BIL_SELECT = 4'h2,
    BIL_LEN = 4'h3,
    BIL_PROG = 4'h4,
    BIL_CHECK = 4'h5,
    BIL_START = 4'h6,
    BIL_RUN = 4'h7,
    BIL_FAIL = 4'h8
  } bil_state_e;

  // RAM write carrier: word address and data
  typedef struct packed {
    logic we;
    logic [31:0] addr;
    logic [31:0] data;
  } bil_ram_wr_s;

endpackage : bil_pkg

// *** src/bil_crc32.sv ***
// Reflected CRC-32 accumulator, one byte per enabled cycle
`timescale 1ns/100ps
module bil_crc32 (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control
  input wire logic init,
  input wire logic en,
  input wire logic [7:0] byte_in,
  // Result
  output logic [31:0] crc_out
);

  logic [31:0] acc_reg;
  logic [31:0] acc_next;

  // Byte update, least significant bit first
  // reflected byte step
  always_comb begin
    acc_next = acc_reg ^ {24'h000000, byte_in};
    for (int i = 0; i < 8; i++) begin
      if (acc_next[0]) begin
        acc_next = (acc_next >> 1) ^ bil_pkg::CRC_POLY;
      end else begin
        acc_next = acc_next >> 1;
      end
    end
  end

  // Accumulator, preset before the first byte
  always_ff @(posedge sys_clk) begin
    if (rst || init) begin
      acc_reg <= bil_pkg::CRC_PRESET;
    end else if (en) begin
      acc_reg <= acc_next;
    end
  end

  // Residue inverted to form the result
  // inverted residue
  assign crc_out = ~acc_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  crc_preset_a: assert property (@(posedge sys_clk) disable iff (rst)
    init |=> crc_out == ~bil_pkg::CRC_PRESET)
    else $error("crc not preset to all ones");
  crc_zero_byte_a: assert property (@(posedge sys_clk) disable iff (rst)
    ((init ##1 (en && byte_in == 8'h00)) or
     (init ##1 !en ##1 (en && byte_in == 8'h00)))
      |=> crc_out == 32'hD202EF8D)
    else $error("crc of single zero byte wrong");

endmodule : bil_crc32

// *** src/bil_word_asm.sv ***
// Gathers bytes into 32-bit words, least significant byte first
`timescale 1ns/100ps
module bil_word_asm (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clear,
  // Byte in
  input wire logic byte_valid,
  input wire logic [7:0] byte_in,
  // Word out, valid with the fourth byte
  output logic word_valid,
  output logic [31:0] word
);

  logic [1:0] lane_reg;
  logic [23:0] low_reg;

  // Lane counter and low bytes
  always_ff @(posedge sys_clk) begin
    if (rst || clear) begin
      lane_reg <= 2'h0;
      low_reg <= 24'h000000;
    end else if (byte_valid) begin
      lane_reg <= lane_reg + 2'h1;
      if (lane_reg != 2'h3) begin
        low_reg[lane_reg*8 +: 8] <= byte_in;
      end
    end
  end

  // Last byte lands in the top lane
  assign word_valid = byte_valid && lane_reg == 2'h3;
  assign word = {byte_in, low_reg};

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  le_order_a: assert property (@(posedge sys_clk)
    disable iff (rst || clear)
    (byte_valid && lane_reg == 2'h0) ##1 (byte_valid [*3])
    |-> word_valid && word[7:0] == $past(byte_in, 3))
    else $error("word not assembled low byte first");

endmodule : bil_word_asm

// *** src/bil_loader.sv ***
// Boot sequencer: internal reset, source select, image load and CRC check
`timescale 1ns/100ps
// How it works
// - Chip reset low holds the loader in reset with GPIO pull-downs enabled.
// - After reset release, wait the internal reset time, then boot.
// - Security bit 5 set selects OTP, otherwise internal flash.
// - Normal source is the embedded quad-SPI flash on tile 0 ports.
// - First field is a 32-bit word count; then that many program words.
// - A check field equal to the bypass value skips CRC verification.
// - Length and check fields are assembled least significant byte first.
// - Program words go to RAM from address zero; execution starts there.
// - CRC covers length field and program bytes, not the check field.
// - CRC uses reflected polynomial EDB88320, bytes processed LSB first.
// - CRC accumulator is preset to all ones before the first byte.
// - Final accumulator is inverted and compared with the check field.
// - Secure boot loads from OTP address zero, bypassing the boot ROM.
module bil_loader #(
  parameter int RAM_WORDS = bil_pkg::RAM_WORDS,
  parameter int INT_RST_CYC = bil_pkg::INT_RST_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Chip pins and security
  input wire logic chip_rst_n,
  input wire logic [31:0] sec_reg,
  output logic gpio_pd_en,
  // Boot source byte stream
  output logic src_start,
  output logic src_otp,
  output logic [31:0] src_base,
  input wire logic src_valid,
  input wire logic [7:0] src_data,
  output logic src_ready,
  // RAM write port
  output bil_pkg::bil_ram_wr_s ram_wr,
  // Processor start and status
  output logic exec_start,
  output logic [31:0] exec_addr,
  output logic busy,
  output logic boot_err
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  localparam int CW = $clog2(INT_RST_CYC + 1);
  localparam logic [CW-1:0] RST_LAST = CW'(INT_RST_CYC - 1);
  localparam logic [31:0] RAM_LIMIT = 32'(RAM_WORDS);

  bil_pkg::bil_state_e state_reg;
  logic [CW-1:0] rst_cnt_reg;
  logic [31:0] len_reg;
  logic [31:0] prog_cnt_reg;
  logic src_otp_reg;
  logic [31:0] src_base_reg;
  logic gpio_pd_reg;
  logic boot_err_reg;
  bil_pkg::bil_ram_wr_s ram_wr_reg;
  logic in_image;
  logic byte_take;
  logic crc_en;
  logic word_valid;
  logic [31:0] word;
  logic [31:0] crc_val;

  // ----------------------------------------------------------------------
  // Stream handshake
  // ----------------------------------------------------------------------
  // Bytes are taken only while parsing the image
  assign in_image = state_reg inside {bil_pkg::BIL_LEN, bil_pkg::BIL_PROG,
                                      bil_pkg::BIL_CHECK};
  assign src_ready = in_image;
  assign byte_take = src_valid && in_image;
  assign crc_en = src_valid && (state_reg == bil_pkg::BIL_LEN ||
                                state_reg == bil_pkg::BIL_PROG);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // bytes low first
  bil_word_asm u_asm (
    .sys_clk(sys_clk),
    .rst(rst),
    .clear(!in_image),
    .byte_valid(byte_take),
    .byte_in(src_data),
    .word_valid(word_valid),
    .word(word)
  );

  bil_crc32 u_crc (
    .sys_clk(sys_clk),
    .rst(rst),
    .init(state_reg == bil_pkg::BIL_SELECT),
    .en(crc_en),
    .byte_in(src_data),
    .crc_out(crc_val)
  );

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // Main state machine; chip reset wins from any state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= bil_pkg::BIL_HELD;
    end else if (!chip_rst_n) begin
      state_reg <= bil_pkg::BIL_HELD;
    end else begin
      unique case (state_reg)
        bil_pkg::BIL_HELD: begin
          state_reg <= bil_pkg::BIL_INT_RST;
        end
        bil_pkg::BIL_INT_RST: begin
          if (rst_cnt_reg == RST_LAST) begin
            state_reg <= bil_pkg::BIL_SELECT;
          end
        end
        bil_pkg::BIL_SELECT: begin
          state_reg <= bil_pkg::BIL_LEN;
        end
        bil_pkg::BIL_LEN: begin
          if (word_valid) begin
            if (word > RAM_LIMIT) begin
              state_reg <= bil_pkg::BIL_FAIL;
            end else if (word == 32'h0000_0000) begin
              state_reg <= bil_pkg::BIL_CHECK;
            end else begin
              state_reg <= bil_pkg::BIL_PROG;
            end
          end
        end
        bil_pkg::BIL_PROG: begin
          if (word_valid && prog_cnt_reg == len_reg - 32'h1) begin
            state_reg <= bil_pkg::BIL_CHECK;
          end
        end
        bil_pkg::BIL_CHECK: begin
          if (word_valid) begin
            if (word == bil_pkg::CRC_BYPASS) begin
              state_reg <= bil_pkg::BIL_START;
            end else if (word == crc_val) begin
              state_reg <= bil_pkg::BIL_START;
            end else begin
              state_reg <= bil_pkg::BIL_FAIL;
            end
          end
        end
        bil_pkg::BIL_START: begin
          state_reg <= bil_pkg::BIL_RUN;
        end
        bil_pkg::BIL_RUN: begin
          state_reg <= bil_pkg::BIL_RUN;
        end
        bil_pkg::BIL_FAIL: begin
          state_reg <= bil_pkg::BIL_FAIL;
        end
        default: begin
          state_reg <= bil_pkg::BIL_HELD;
        end
      endcase
    end
  end

  // Internal reset counter
  always_ff @(posedge sys_clk) begin
    if (rst || state_reg != bil_pkg::BIL_INT_RST) begin
      rst_cnt_reg <= '0;
    end else if (rst_cnt_reg != RST_LAST) begin
      rst_cnt_reg <= rst_cnt_reg + CW'(1);
    end
  end

  // Length field and program word index
  always_ff @(posedge sys_clk) begin
    if (rst || state_reg == bil_pkg::BIL_SELECT) begin
      len_reg <= 32'h0000_0000;
      prog_cnt_reg <= 32'h0000_0000;
    end else if (word_valid && state_reg == bil_pkg::BIL_LEN) begin
      len_reg <= word;
    end else if (word_valid && state_reg == bil_pkg::BIL_PROG) begin
      prog_cnt_reg <= prog_cnt_reg + 32'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------------
  // Security bit sampled as the boot phase begins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      src_otp_reg <= 1'b0;
      src_base_reg <= 32'h0000_0000;
    end else if (state_reg == bil_pkg::BIL_INT_RST &&
                 rst_cnt_reg == RST_LAST) begin
      src_otp_reg <= sec_reg[bil_pkg::SEC_BOOT_BIT];
      if (sec_reg[bil_pkg::SEC_BOOT_BIT]) begin
        src_base_reg <= bil_pkg::OTP_BASE;
      end else begin
        src_base_reg <= bil_pkg::FLASH_BASE;
      end
    end
  end

  assign src_start = state_reg == bil_pkg::BIL_SELECT;
  assign src_otp = src_otp_reg;
  assign src_base = src_base_reg;

  // ----------------------------------------------------------------------
  // RAM writes and start
  // ----------------------------------------------------------------------
  // program from word zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ram_wr_reg <= '0;
    end else begin
      ram_wr_reg.we <= word_valid && state_reg == bil_pkg::BIL_PROG;
      ram_wr_reg.addr <= prog_cnt_reg;
      ram_wr_reg.data <= word;
    end
  end

  assign ram_wr = ram_wr_reg;
  assign exec_start = state_reg == bil_pkg::BIL_START;
  assign exec_addr = bil_pkg::EXEC_ADDR;

  // ----------------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------------
  // pull-downs and error flag
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gpio_pd_reg <= 1'b1;
      boot_err_reg <= 1'b0;
    end else begin
      gpio_pd_reg <= !chip_rst_n;
      boot_err_reg <= chip_rst_n && (boot_err_reg ||
                      state_reg == bil_pkg::BIL_FAIL);
    end
  end

  assign gpio_pd_en = gpio_pd_reg;
  assign boot_err = boot_err_reg;
  assign busy = state_reg inside {bil_pkg::BIL_SELECT, bil_pkg::BIL_LEN,
                                  bil_pkg::BIL_PROG, bil_pkg::BIL_CHECK};

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  held_pulldown_a: assert property (@(posedge sys_clk) disable iff (rst)
    !chip_rst_n |=> gpio_pd_en && state_reg == bil_pkg::BIL_HELD && !busy)
    else $error("chip reset did not hold loader");
  boot_delay_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == bil_pkg::BIL_SELECT) |->
      $past(state_reg) == bil_pkg::BIL_INT_RST &&
      $past(rst_cnt_reg) == RST_LAST)
    else $error("boot began before internal reset ended");
  src_pick_a: assert property (@(posedge sys_clk) disable iff (rst)
    src_start |-> src_otp == $past(sec_reg[bil_pkg::SEC_BOOT_BIT]))
    else $error("boot source not from security bit");
  src_base_a: assert property (@(posedge sys_clk) disable iff (rst)
    src_start |-> src_base == 32'h0000_0000)
    else $error("source not read from address zero");
  crc_scope_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == bil_pkg::BIL_CHECK) |-> !crc_en &&
      ($past(state_reg) != bil_pkg::BIL_CHECK || $stable(crc_val)))
    else $error("check field fed into crc");
  ram_addr_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == bil_pkg::BIL_PROG && word_valid && prog_cnt_reg == 32'h0)
      |=> ram_wr.we && ram_wr.addr == 32'h0 && ram_wr.data == $past(word))
    else $error("first program word not at address zero");
  bypass_start_a: assert property (@(posedge sys_clk) disable iff (rst)
    (chip_rst_n && state_reg == bil_pkg::BIL_CHECK && word_valid &&
     word == bil_pkg::CRC_BYPASS) |=> exec_start)
    else $error("bypass value did not start program");
  crc_fail_a: assert property (@(posedge sys_clk) disable iff (rst)
    (chip_rst_n && state_reg == bil_pkg::BIL_CHECK && word_valid &&
     word != bil_pkg::CRC_BYPASS && word != crc_val) ##1 chip_rst_n
      |=> boot_err && !exec_start)
    else $error("crc mismatch not flagged");
  busy_span_a: assert property (@(posedge sys_clk) disable iff (rst)
    exec_start |-> $past(busy) && !busy)
    else $error("busy not held until start");

  run_bypass_c: cover property (@(posedge sys_clk) disable iff (rst)
    state_reg == bil_pkg::BIL_CHECK && word_valid &&
    word == bil_pkg::CRC_BYPASS);
  run_crc_ok_c: cover property (@(posedge sys_clk) disable iff (rst)
    state_reg == bil_pkg::BIL_CHECK && word_valid && word == crc_val);
  run_crc_bad_c: cover property (@(posedge sys_clk) disable iff (rst)
    state_reg == bil_pkg::BIL_FAIL);
  run_otp_c: cover property (@(posedge sys_clk) disable iff (rst)
    src_start && src_otp);

endmodule : bil_loader

// *** bench/bil_flash_model.sv ***
// Behavioural boot flash that streams a loaded image one byte at a time
`timescale 1ns/100ps
module bil_flash_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Stream to the loader
  input wire logic src_start,
  input wire logic src_ready,
  output logic src_valid,
  output logic [7:0] src_data
);
  // ----------------------------------------------------------------------
  // Image store, loaded by the bench
  // ----------------------------------------------------------------------
  logic [7:0] mem [0:63];
  int n_bytes = 0;
  bit slow = 1'h0;
  int ptr = 0;
  bit active = 1'h0;

  initial begin
    src_valid = 1'h0;
    src_data = 8'h00;
  end

  // Offer a byte, hold it until taken; released data lines toggle
  always @(posedge sys_clk) begin
    if (rst) begin
      active <= 1'h0;
      src_valid <= 1'h0;
      src_data <= ~src_data;
    end else if (src_start) begin
      active <= 1'h1;
      ptr <= 0;
      src_valid <= 1'h0;
      src_data <= ~src_data;
    end else if (active) begin
      if (src_valid && src_ready) begin
        ptr <= ptr + 1;
        src_valid <= !slow && (ptr + 1 < n_bytes);
        src_data <= (!slow && ptr + 1 < n_bytes) ? mem[ptr + 1] : ~src_data;
      end else if (!src_valid && ptr < n_bytes) begin
        src_valid <= 1'h1;
        src_data <= mem[ptr];
      end else if (!src_valid) begin
        src_data <= ~src_data;
      end
    end
  end
endmodule : bil_flash_model

// *** bench/tb_top.sv ***
// Self-checking bench for the boot image loader
`timescale 1ns/100ps
module tb_top;
  // ----------------------------------------------------------------------
  // Signals and design under test
  // ----------------------------------------------------------------------
  localparam int TB_RAM = 8;
  localparam int TB_RST = 4;
  logic sys_clk, rst, chip_rst_n, gpio_pd_en;
  logic [31:0] sec_reg, src_base, exec_addr;
  logic src_start, src_otp, src_valid, src_ready, exec_start, busy, boot_err;
  logic [7:0] src_data;
  bil_pkg::bil_ram_wr_s ram_wr;
  logic [31:0] img [0:15];
  int err_count = 0;
  int comparisons = 0;

  bil_loader #(.RAM_WORDS(TB_RAM), .INT_RST_CYC(TB_RST)) u_dut (
    .sys_clk(sys_clk), .rst(rst), .chip_rst_n(chip_rst_n),
    .sec_reg(sec_reg), .gpio_pd_en(gpio_pd_en), .src_start(src_start),
    .src_otp(src_otp), .src_base(src_base), .src_valid(src_valid),
    .src_data(src_data), .src_ready(src_ready), .ram_wr(ram_wr),
    .exec_start(exec_start), .exec_addr(exec_addr), .busy(busy),
    .boot_err(boot_err)
  );

  bil_flash_model u_flash (
    .sys_clk(sys_clk), .rst(rst), .src_start(src_start),
    .src_ready(src_ready), .src_valid(src_valid), .src_data(src_data)
  );

  // 20 MHz clock
  initial begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  // Reflected CRC step over one byte
  function automatic logic [31:0] crc_add(input logic [31:0] c,
                                          input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ bil_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_add

  // Image into the flash, fields LSB first; mode 0 good, 1 bypass, 2 bad
  task automatic load_image(input logic [31:0] len, input int nw,
                            input int mode);
    logic [31:0] c, chk;
    int k;
    c = bil_pkg::CRC_PRESET;
    k = 0;
    for (int i = 0; i < 4; i++) begin
      u_flash.mem[k++] = len[8*i+:8];
      c = crc_add(c, len[8*i+:8]);
    end
    for (int w = 0; w < nw; w++) begin
      img[w] = {8'(w + 1), 8'h5A, 8'(w * 3), 8'hC3};
      for (int i = 0; i < 4; i++) begin
        u_flash.mem[k++] = img[w][8*i+:8];
        c = crc_add(c, img[w][8*i+:8]);
      end
    end
    chk = (mode == 0) ? ~c : (mode == 1) ? bil_pkg::CRC_BYPASS : c;
    for (int i = 0; i < 4; i++) begin
      u_flash.mem[k++] = chk[8*i+:8];
    end
    u_flash.n_bytes = k;
  endtask : load_image

  // One boot from chip reset to start or error
  task automatic run_boot(input logic [31:0] sec, input logic [31:0] len,
                          input int nw, input int mode, input bit slow,
                          input bit ok, input int exp_wr);
    int n, wc;
    bit seen_ok, seen_err;
    n = 0;
    wc = 0;
    seen_ok = 1'h0;
    seen_err = 1'h0;
    u_flash.slow = slow;
    load_image(len, nw, mode);
    @(posedge sys_clk);
    chip_rst_n <= 1'h0;
    sec_reg <= sec;
    repeat (3) @(posedge sys_clk);
    #1;
    check(gpio_pd_en, 1'h1);
    check(boot_err, 1'h0);
    check(busy, 1'h0);
    @(posedge sys_clk);
    chip_rst_n <= 1'h1;
    while (src_start !== 1'h1 && n < 400) begin
      @(posedge sys_clk);
      n++;
      #1;
    end
    check(32'(n), 32'(TB_RST + 1));
    check(busy, 1'h1);
    check(gpio_pd_en, 1'h0);
    check(src_otp, sec[bil_pkg::SEC_BOOT_BIT]);
    check(src_base, bil_pkg::OTP_BASE);
    n = 0;
    while (!seen_ok && !seen_err && n < 600) begin
      @(posedge sys_clk);
      n++;
      #1;
      if (ram_wr.we === 1'h1 && wc < 16) begin
        check(ram_wr.addr, 32'(wc));
        check(ram_wr.data, img[wc]);
        wc++;
      end
      if (exec_start === 1'h1) begin
        seen_ok = 1'h1;
        check(exec_addr, bil_pkg::EXEC_ADDR);
        check(busy, 1'h0);
      end
      if (boot_err === 1'h1) begin
        seen_err = 1'h1;
      end
    end
    check(seen_ok, ok);
    check(seen_err, !ok);
    check(32'(wc), 32'(exp_wr));
    repeat (3) begin
      @(posedge sys_clk);
      #1;
      check(exec_start, 1'h0);
      check(src_ready, 1'h0);
      check(busy, 1'h0);
    end
  endtask : run_boot

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // flash boot with CRC
  task automatic t_flash_crc;
    run_boot(32'hFFFFFFDF, 32'h00000003, 3, 0, 1'h0, 1'h1, 3);
  endtask : t_flash_crc

  task automatic t_otp_bypass;
    run_boot(32'h00000020, 32'h00000002, 2, 1, 1'h1, 1'h1, 2);
  endtask : t_otp_bypass

  task automatic t_bad_crc;
    run_boot(32'h00000000, 32'h00000002, 2, 2, 1'h0, 1'h0, 2);
  endtask : t_bad_crc

  // empty program, CRC over length only
  task automatic t_zero_len;
    run_boot(32'h00000000, 32'h00000000, 0, 0, 1'h1, 1'h1, 0);
  endtask : t_zero_len

  task automatic t_too_long;
    run_boot(32'h00000000, 32'(TB_RAM + 1), TB_RAM + 1, 0, 1'h0, 1'h0,
             0);
  endtask : t_too_long

  // chip reset mid-load aborts the boot
  task automatic t_abort;
    load_image(32'h00000004, 4, 0);
    @(posedge sys_clk);
    chip_rst_n <= 1'h0;
    sec_reg <= 32'h00000000;
    repeat (3) @(posedge sys_clk);
    chip_rst_n <= 1'h1;
    repeat (TB_RST + 12) @(posedge sys_clk);
    #1;
    check(busy, 1'h1);
    @(posedge sys_clk);
    chip_rst_n <= 1'h0;
    repeat (20) begin
      @(posedge sys_clk);
      #1;
      check(exec_start, 1'h0);
    end
    check(gpio_pd_en, 1'h1);
    check(busy, 1'h0);
    check(boot_err, 1'h0);
  endtask : t_abort

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    rst = 1'h1;
    chip_rst_n = 1'h0;
    sec_reg = 32'h00000000;
    repeat (4) @(posedge sys_clk);
    rst <= 1'h0;
    repeat (20000) @(posedge sys_clk);
    #1;
    check(gpio_pd_en, 1'h1);
    t_flash_crc();
    t_otp_bypass();
    t_bad_crc();
    t_zero_len();
    t_too_long();
    t_abort();
    t_flash_crc();
    tally_and_finish();
  end

  initial begin
    repeat (40000) @(posedge sys_clk);
    err_count++;
    tally_and_finish();
  end
endmodule : tb_top
